//--- core/isa_forward_decoder.sv
/*
 * Decides for each ISA master or DMA memory cycle whether it is forwarded
 * to PCI or kept on ISA, with the configuration registers behind a plain
 * address/strobe port. Assumes all inputs synchronous to sys_clk, one
 * cycle request per clock at most, and the boot ROM chip-select enable
 * supplied by the utility bus select register elsewhere in the device.
 */
// How it works
// - Control bits 7:4 set top of extended region, 1 Mbyte steps from 1 Mbyte.
// - Extended region cycles from 1 Mbyte to top go to PCI, except hole.
// - Control bits 3:0 are per-block forward enables, 1 enables.
// - Cycles into an enabled low block are forwarded to PCI, the boot ROM block only with chip select off.
// - Bits map to 0-512K, 512-640K, 640-768K video, 896-960K boot ROM.
// - Boot ROM chip select on keeps 896-960K on ISA regardless of bit 3.
// - Boot ROM chip select off forwards 896-960K only when bit 3 set.
// - Eight ROM-area enables, one per 16K slice from 768K to 896K.
// - Enabled ROM slices forward to PCI, disabled ones stay on ISA.
// - Addresses from 1 Mbyte up between hole bottom and hole top inclusive never go to PCI.
// - Hole bottom compares all eight bits against A[23:16].
// - Hole top compares against A[23:16], whole named 64K block included.
// - Hole top below hole bottom disables the hole.
// - Hole bottom resets to 10h and hole top to 0Fh.
`timescale 1ns/1ps
module isa_forward_decoder #(
    parameter int ADDR_W = 24
) (
    // Clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Boot ROM chip-select enable from elsewhere in the device
    input  wire logic              boot_rom_cs_enable,
    // Memory cycle from ISA master or DMA
    input  wire logic              cyc_valid,
    input  wire logic [ADDR_W-1:0] cyc_addr,
    // Decision, one cycle after the request
    output logic                   fwd_valid,
    output logic                   fwd_to_pci,
    output logic                   fwd_keep_isa,
    output logic      [2:0]        fwd_class
);

    // --------------------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------------------
    if (ADDR_W < fwd_dec_pkg::ISA_ADDR_W || ADDR_W > 32) begin : g_bad_width
        $error("ADDR_W must lie between 24 and 32");
    end

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    function automatic logic in_span(input logic [7:0] v,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
        in_span = (v >= lo) && (v <= hi);
    endfunction : in_span

    function automatic logic hole_on(input logic [7:0] lo,
                                     input logic [7:0] hi);
        hole_on = (hi >= lo);
    endfunction : hole_on

    // --------------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------------
    logic [7:0] isa_forward_control;
    logic [7:0] rom_window_forward_enable;
    logic [7:0] forward_hole_bottom;
    logic [7:0] forward_hole_top;
    logic [7:0] last_status;
    logic [7:0] next_isa_forward_control;
    logic [7:0] next_rom_window_forward_enable;
    logic [7:0] next_forward_hole_bottom;
    logic [7:0] next_forward_hole_top;
    logic [7:0] next_reg_rdata;

    always_comb begin
        next_isa_forward_control       = isa_forward_control;
        next_rom_window_forward_enable = rom_window_forward_enable;
        next_forward_hole_bottom       = forward_hole_bottom;
        next_forward_hole_top          = forward_hole_top;
        next_reg_rdata                 = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                fwd_dec_pkg::OFF_CONTROL:     next_isa_forward_control = reg_wdata;
                fwd_dec_pkg::OFF_ROM_ENABLE:  next_rom_window_forward_enable = reg_wdata;
                fwd_dec_pkg::OFF_HOLE_BOTTOM: next_forward_hole_bottom = reg_wdata;
                fwd_dec_pkg::OFF_HOLE_TOP:    next_forward_hole_top = reg_wdata;
                default: ;
            endcase
        end
        // Unmapped offsets read as zero
        if (reg_rd) begin
            unique case (reg_addr)
                fwd_dec_pkg::OFF_CONTROL:     next_reg_rdata = isa_forward_control;
                fwd_dec_pkg::OFF_ROM_ENABLE:  next_reg_rdata = rom_window_forward_enable;
                fwd_dec_pkg::OFF_HOLE_BOTTOM: next_reg_rdata = forward_hole_bottom;
                fwd_dec_pkg::OFF_HOLE_TOP:    next_reg_rdata = forward_hole_top;
                fwd_dec_pkg::OFF_STATUS:      next_reg_rdata = last_status;
                default:                      next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            isa_forward_control       <= fwd_dec_pkg::RST_CONTROL;
            rom_window_forward_enable <= fwd_dec_pkg::RST_ROM_ENABLE;
            forward_hole_bottom       <= fwd_dec_pkg::RST_HOLE_BOTTOM;
            forward_hole_top          <= fwd_dec_pkg::RST_HOLE_TOP;
            reg_rdata                 <= 8'h00;
        end else if (ce) begin
            isa_forward_control       <= next_isa_forward_control;
            rom_window_forward_enable <= next_rom_window_forward_enable;
            forward_hole_bottom       <= next_forward_hole_bottom;
            forward_hole_top          <= next_forward_hole_top;
            reg_rdata                 <= next_reg_rdata;
        end
    end

    // --------------------------------------------------------------------
    // Address decode
    // --------------------------------------------------------------------
    logic [7:0]        page;
    logic [3:0]        meg;
    logic [2:0]        slice;
    logic [ADDR_W:0]   addr_ext;
    logic              above_16m;
    logic              in_region;
    logic              in_hole;
    logic              decide_pci;
    fwd_dec_pkg::cls_t page_cls;
    fwd_dec_pkg::cls_t cls;

    assign page     = cyc_addr[fwd_dec_pkg::PAGE_LSB +: 8];
    assign meg      = cyc_addr[fwd_dec_pkg::MEG_LSB +: 4];
    assign slice    = cyc_addr[fwd_dec_pkg::SLICE_LSB +: 3];
    assign addr_ext = {1'b0, cyc_addr};
    // Bits above A23 push the address out of every decoded range
    assign above_16m = (addr_ext >> fwd_dec_pkg::ISA_ADDR_W) != '0;

    page_classifier u_page_classifier (
        .page (page),
        .cls  (page_cls)
    );

    assign cls = above_16m ? fwd_dec_pkg::CLS_ABOVE : page_cls;

    // Top code N means the region ends just below N+1 Mbytes
    assign in_region = (meg <= isa_forward_control[fwd_dec_pkg::CTL_TOP_MSB:
                                                    fwd_dec_pkg::CTL_TOP_LSB]);

    // Both limits are whole 64K pages, so the top page is covered to its last byte
    assign in_hole = hole_on(forward_hole_bottom, forward_hole_top)
                     && in_span(page, forward_hole_bottom, forward_hole_top);

    always_comb begin
        decide_pci = 1'b0;
        unique case (cls)
            fwd_dec_pkg::CLS_LOW_BASE:
                decide_pci = isa_forward_control[fwd_dec_pkg::CTL_BLK_LOW];
            fwd_dec_pkg::CLS_LOW_EXT:
                decide_pci = isa_forward_control[fwd_dec_pkg::CTL_BLK_EXT];
            fwd_dec_pkg::CLS_VIDEO:
                decide_pci = isa_forward_control[fwd_dec_pkg::CTL_BLK_VIDEO];
            fwd_dec_pkg::CLS_ROM_AREA:
                decide_pci = rom_window_forward_enable[slice];
            fwd_dec_pkg::CLS_BOOT_ROM:
                decide_pci = !boot_rom_cs_enable
                             && isa_forward_control[fwd_dec_pkg::CTL_BLK_BOOT];
            fwd_dec_pkg::CLS_HIGH_BIOS:
                decide_pci = 1'b0;
            fwd_dec_pkg::CLS_EXTENDED:
                // Hole is only looked at here, never for the low ranges
                decide_pci = in_region && !in_hole;
            fwd_dec_pkg::CLS_ABOVE:
                decide_pci = 1'b0;
        endcase
    end

    // --------------------------------------------------------------------
    // Decision register
    // --------------------------------------------------------------------
    logic       next_fwd_valid;
    logic       next_fwd_to_pci;
    logic       next_fwd_keep_isa;
    logic [2:0] next_fwd_class;
    logic [7:0] next_last_status;

    always_comb begin
        next_fwd_valid    = cyc_valid;
        next_fwd_to_pci   = cyc_valid && decide_pci;
        next_fwd_keep_isa = cyc_valid && !decide_pci;
        next_fwd_class    = cyc_valid ? cls : fwd_class;
        next_last_status  = last_status;
        next_last_status[fwd_dec_pkg::STS_HOLE_ON] =
            hole_on(forward_hole_bottom, forward_hole_top);
        if (cyc_valid) begin
            next_last_status[fwd_dec_pkg::STS_FORWARD] = decide_pci;
            next_last_status[fwd_dec_pkg::STS_CLS_MSB:fwd_dec_pkg::STS_CLS_LSB] = cls;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fwd_valid    <= 1'b0;
            fwd_to_pci   <= 1'b0;
            fwd_keep_isa <= 1'b0;
            fwd_class    <= 3'h0;
            last_status  <= fwd_dec_pkg::RST_STATUS;
        end else if (ce) begin
            fwd_valid    <= next_fwd_valid;
            fwd_to_pci   <= next_fwd_to_pci;
            fwd_keep_isa <= next_fwd_keep_isa;
            fwd_class    <= next_fwd_class;
            last_status  <= next_last_status;
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic req;
    assign req = ce && cyc_valid && !above_16m;

    AST_RESET_VALUES: assert property ($fell(rst) |->
        forward_hole_bottom == 8'h10 && forward_hole_top == 8'h0F)
        else $error("hole limits not at reset values after reset");

    AST_LOW_BLOCK: assert property (req && page < 8'h08 |=>
        fwd_valid && fwd_to_pci == $past(isa_forward_control[0]))
        else $error("0-512K block decision does not follow enable bit 0");

    AST_VIDEO_BLOCK: assert property (req && (page == 8'h0A || page == 8'h0B) |=>
        fwd_to_pci == $past(isa_forward_control[2]))
        else $error("640-768K block decision does not follow enable bit 2");

    AST_BOOT_OVERRIDE: assert property (req && page == 8'h0E && boot_rom_cs_enable |=>
        fwd_keep_isa && !fwd_to_pci)
        else $error("boot ROM cycle forwarded while chip select enabled");

    AST_BOOT_FORWARD: assert property (req && page == 8'h0E && !boot_rom_cs_enable |=>
        fwd_to_pci == $past(isa_forward_control[3]))
        else $error("boot ROM cycle decision does not follow bit 3");

    AST_ROM_SLICE: assert property (req && (page == 8'h0C || page == 8'h0D) |=>
        fwd_to_pci == $past(rom_window_forward_enable[cyc_addr[16:14]]))
        else $error("ROM slice decision does not follow its enable");

    AST_HOLE_BLOCKS: assert property (req && page >= 8'h10
        && page >= forward_hole_bottom && page <= forward_hole_top |=> fwd_keep_isa)
        else $error("address inside the hole forwarded to PCI");

    AST_HOLE_OFF: assert property (req && page >= 8'h10
        && forward_hole_top < forward_hole_bottom
        && cyc_addr[23:20] <= isa_forward_control[7:4] |=> fwd_to_pci)
        else $error("disabled hole still blocks forwarding");

    AST_REGION_TOP: assert property (req && page >= 8'h10
        && cyc_addr[23:20] > isa_forward_control[7:4] |=> fwd_keep_isa)
        else $error("address above region top forwarded");

    AST_HIGH_BIOS: assert property (req && page == 8'h0F |=> fwd_keep_isa)
        else $error("960K-1M cycle forwarded to PCI");

    AST_ONE_ANSWER: assert property (ce && cyc_valid |=>
        fwd_valid && (fwd_to_pci ^ fwd_keep_isa) && fwd_class == $past(cls))
        else $error("cycle answered with both or neither decision");

    AST_NO_REQ_QUIET: assert property (ce && !cyc_valid |=>
        !fwd_valid && !fwd_to_pci && !fwd_keep_isa && $stable(fwd_class))
        else $error("decision given without a request");

    AST_EXT_BLOCK: assert property (req && (page == 8'h08 || page == 8'h09) |=>
        fwd_to_pci == $past(isa_forward_control[1]))
        else $error("512-640K block decision does not follow enable bit 1");

    // Just outside either end of the hole the region forwards again
    AST_BELOW_HOLE: assert property (req && page >= 8'h10 && page < forward_hole_bottom
        && cyc_addr[23:20] <= isa_forward_control[7:4] |=> fwd_to_pci)
        else $error("page below the hole kept on ISA");

    AST_ABOVE_HOLE: assert property (req && page >= 8'h10 && page > forward_hole_top
        && cyc_addr[23:20] <= isa_forward_control[7:4] |=> fwd_to_pci)
        else $error("page above the hole kept on ISA");

    AST_ROM_CLASS: assert property (req && (page == 8'h0C || page == 8'h0D) |=>
        fwd_class == fwd_dec_pkg::CLS_ROM_AREA)
        else $error("768-896K cycle not classed as ROM area");

    AST_BOOT_CLASS: assert property (req && page == 8'h0E |=>
        fwd_class == fwd_dec_pkg::CLS_BOOT_ROM)
        else $error("896-960K cycle not classed as boot ROM");

    AST_EXT_CLASS: assert property (req && page >= 8'h10 |=>
        fwd_class == fwd_dec_pkg::CLS_EXTENDED)
        else $error("cycle above 1 Mbyte not classed as extended");

    AST_HOLE_STATUS: assert property (ce |=>
        last_status[fwd_dec_pkg::STS_HOLE_ON] == $past(forward_hole_top >= forward_hole_bottom))
        else $error("hole enable status does not follow the limits");

    // Register port and clock enable
    AST_WRITE_LANDS: assert property (ce && reg_wr
        && reg_addr == fwd_dec_pkg::OFF_CONTROL |=> isa_forward_control == $past(reg_wdata))
        else $error("control write did not land");

    AST_READ_BOTTOM: assert property (ce && reg_rd
        && reg_addr == fwd_dec_pkg::OFF_HOLE_BOTTOM |=> reg_rdata == $past(forward_hole_bottom))
        else $error("hole bottom read back wrong");

    AST_LIMITS_HOLD: assert property (!(ce && reg_wr) |=>
        $stable(forward_hole_bottom) && $stable(forward_hole_top))
        else $error("hole limits changed without a write");

    AST_CE_FREEZE: assert property (!ce |=>
        $stable(fwd_valid) && $stable(fwd_to_pci) && $stable(fwd_keep_isa))
        else $error("decision changed while clock enable low");

    // --------------------------------------------------------------------
    // Cover points
    // --------------------------------------------------------------------
    COV_EXTENDED_FWD: cover property (req && page >= 8'h10 ##1 fwd_to_pci);
    COV_HOLE_HIT: cover property (req && in_hole && page >= 8'h10 ##1 fwd_keep_isa);
    COV_ROM_FWD: cover property (req && cls == fwd_dec_pkg::CLS_ROM_AREA ##1 fwd_to_pci);
    COV_BOOT_KEEP: cover property (req && page == 8'h0E && boot_rom_cs_enable ##1 fwd_keep_isa);
    COV_LOW_FWD: cover property (req && page < 8'h08 ##1 fwd_to_pci);

endmodule : isa_forward_decoder

//--- core/fwd_dec_pkg.sv
/*
 * Constants for the ISA/DMA memory forwarding decoder: register offsets,
 * reset values, field positions, address page boundaries and decode classes.
 * Assumes byte-wide registers on a plain address/strobe port.
 */
package fwd_dec_pkg;

    // --------------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL     = 8'h48;
    localparam logic [7:0] OFF_ROM_ENABLE  = 8'h49;
    localparam logic [7:0] OFF_HOLE_BOTTOM = 8'h4A;
    localparam logic [7:0] OFF_HOLE_TOP    = 8'h4B;
    localparam logic [7:0] OFF_STATUS      = 8'h5F;

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL     = 8'h01;
    localparam logic [7:0] RST_ROM_ENABLE  = 8'h00;
    localparam logic [7:0] RST_HOLE_BOTTOM = 8'h10;
    localparam logic [7:0] RST_HOLE_TOP    = 8'h0F;
    localparam logic [7:0] RST_STATUS      = 8'h00;

    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int CTL_TOP_MSB   = 7;
    localparam int CTL_TOP_LSB   = 4;
    localparam int CTL_BLK_LOW   = 0;
    localparam int CTL_BLK_EXT   = 1;
    localparam int CTL_BLK_VIDEO = 2;
    localparam int CTL_BLK_BOOT  = 3;
    localparam int STS_HOLE_ON   = 0;
    localparam int STS_FORWARD   = 1;
    localparam int STS_CLS_LSB   = 2;
    localparam int STS_CLS_MSB   = 4;

    // --------------------------------------------------------------------
    // Address layout, pages are 64-Kbyte units on A[23:16]
    // --------------------------------------------------------------------
    localparam int ISA_ADDR_W  = 24;
    localparam int PAGE_LSB    = 16;
    localparam int MEG_LSB     = 20;
    localparam int SLICE_LSB   = 14;
    localparam logic [7:0] PG_EXT   = 8'h08;
    localparam logic [7:0] PG_VIDEO = 8'h0A;
    localparam logic [7:0] PG_ROM   = 8'h0C;
    localparam logic [7:0] PG_BOOT  = 8'h0E;
    localparam logic [7:0] PG_BIOS  = 8'h0F;
    localparam logic [7:0] PG_MEG1  = 8'h10;

    // --------------------------------------------------------------------
    // Decode classes
    // --------------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_LOW_BASE,
        CLS_LOW_EXT,
        CLS_VIDEO,
        CLS_ROM_AREA,
        CLS_BOOT_ROM,
        CLS_HIGH_BIOS,
        CLS_EXTENDED,
        CLS_ABOVE
    } cls_t;

endpackage : fwd_dec_pkg

//--- core/page_classifier.sv
/*
 * Sorts a 64-Kbyte page number of an ISA memory address into its
 * decode class. Purely combinational; the caller registers the result
 * and handles addresses at or above 16 Mbytes.
 */
`timescale 1ns/1ps
module page_classifier (
    // Address page A[23:16]
    input  wire logic [7:0]          page,
    // Decode class
    output fwd_dec_pkg::cls_t        cls
);

    // --------------------------------------------------------------------
    // Page ranges, lowest first
    // --------------------------------------------------------------------
    always_comb begin
        if (page < fwd_dec_pkg::PG_EXT) begin
            cls = fwd_dec_pkg::CLS_LOW_BASE;
        end else if (page < fwd_dec_pkg::PG_VIDEO) begin
            cls = fwd_dec_pkg::CLS_LOW_EXT;
        end else if (page < fwd_dec_pkg::PG_ROM) begin
            cls = fwd_dec_pkg::CLS_VIDEO;
        end else if (page < fwd_dec_pkg::PG_BOOT) begin
            cls = fwd_dec_pkg::CLS_ROM_AREA;
        end else if (page < fwd_dec_pkg::PG_BIOS) begin
            cls = fwd_dec_pkg::CLS_BOOT_ROM;
        end else if (page < fwd_dec_pkg::PG_MEG1) begin
            cls = fwd_dec_pkg::CLS_HIGH_BIOS;
        end else begin
            cls = fwd_dec_pkg::CLS_EXTENDED;
        end
    end

endmodule : page_classifier

//--- testbench/isa_master_model.sv
/*
 * Behavioural ISA master / DMA source feeding memory cycles to the decoder.
 * Assumes the bench raises req just after a rising edge, one cycle a request.
 */
`timescale 1ns/1ps
module isa_master_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Requests from the bench
    input  wire logic        req,
    input  wire logic [23:0] req_addr,
    // Memory cycle toward the decoder
    output logic             cyc_valid,
    output logic      [23:0] cyc_addr
);
    logic [23:0] last_addr;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last_addr <= 24'h000000;
        end else if (req) begin
            last_addr <= req_addr;
        end
    end

    // Released lines show the inverse, so a stale address never passes for valid
    assign cyc_valid = req;
    assign cyc_addr  = req ? req_addr : ~last_addr;
endmodule : isa_master_model

//--- testbench/isa_to_pci_memory_forward_decoder_bench.sv
/*
 * Self-checking bench for the forwarding decoder: register tasks, reference
 * decode and a monitor fed by queues of expectations.
 * Assumes answers one cycle after each request.
 */
`timescale 1ns/1ps
module isa_to_pci_memory_forward_decoder_bench;
    logic        sys_clk, rst, ce, reg_wr, reg_rd, req, boot_rom_cs_enable;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [23:0] req_addr, cyc_addr, lfsr, a;
    logic        cyc_valid, fwd_valid, fwd_to_pci, fwd_keep_isa, rd_seen, cyc_seen;
    logic [2:0]  fwd_class;
    logic [7:0]  ctl, rom, bot, top;
    logic [3:0]  last_exp;
    logic [7:0]  exp_rd[$];
    logic [3:0]  exp_fwd[$];
    int          err_total, checks_done;
    logic [23:0] low_tab[10] = '{24'h000000, 24'h07FFFF, 24'h080000, 24'h09FFFF, 24'h0A0000,
                                 24'h0BFFFF, 24'h0E0000, 24'h0EFFFF, 24'h0F0000, 24'h0FFFFF};

    isa_master_model src (.sys_clk(sys_clk), .rst(rst), .req(req), .req_addr(req_addr),
                          .cyc_valid(cyc_valid), .cyc_addr(cyc_addr));
    isa_forward_decoder #(.ADDR_W(24)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .boot_rom_cs_enable(boot_rom_cs_enable),
        .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .fwd_valid(fwd_valid),
        .fwd_to_pci(fwd_to_pci), .fwd_keep_isa(fwd_keep_isa), .fwd_class(fwd_class));

    // ------------------------------------------------------------------
    // Reference decode, reads shadow registers
    // ------------------------------------------------------------------
    function automatic logic [3:0] fwd_exp(input logic [23:0] ad, input logic bcs);
        logic [7:0] pg;
        pg = ad[23:16];
        if (pg < fwd_dec_pkg::PG_EXT) return {ctl[0], 3'h0};
        if (pg < fwd_dec_pkg::PG_VIDEO) return {ctl[1], 3'h1};
        if (pg < fwd_dec_pkg::PG_ROM) return {ctl[2], 3'h2};
        if (pg < fwd_dec_pkg::PG_BOOT) return {rom[ad[16:14]], 3'h3};
        if (pg < fwd_dec_pkg::PG_BIOS) return {!bcs && ctl[3], 3'h4};
        if (pg < fwd_dec_pkg::PG_MEG1) return {1'b0, 3'h5};
        return {(ad[23:20] <= ctl[7:4]) && !(top >= bot && pg >= bot && pg <= top), 3'h6};
    endfunction : fwd_exp

    function automatic logic [23:0] lfsr_next(input logic [23:0] s);
        return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
    endfunction : lfsr_next

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Drivers; each owns one edge, so strobes never get two values at once
    // ------------------------------------------------------------------
    task automatic strobe(input logic w, input logic r, input logic q);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        req    <= q;
    endtask : strobe

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        strobe(1'b1, 1'b0, 1'b0);
        reg_addr  <= ad;
        reg_wdata <= d;
        case (ad)
            fwd_dec_pkg::OFF_CONTROL: ctl = d;
            fwd_dec_pkg::OFF_ROM_ENABLE: rom = d;
            fwd_dec_pkg::OFF_HOLE_BOTTOM: bot = d;
            fwd_dec_pkg::OFF_HOLE_TOP: top = d;
            default: ;
        endcase
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        strobe(1'b0, 1'b1, 1'b0);
        reg_addr <= ad;
        exp_rd.push_back(exp);
    endtask : rd

    task automatic cyc(input logic [23:0] ad, input logic bcs);
        strobe(1'b0, 1'b0, 1'b1);
        req_addr           <= ad;
        boot_rom_cs_enable <= bcs;
        last_exp = fwd_exp(ad, bcs);
        exp_fwd.push_back(last_exp);
    endtask : cyc

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_seen  <= 1'b0;
            cyc_seen <= 1'b0;
        end else begin
            rd_seen  <= reg_rd & ce;
            cyc_seen <= req & ce;
        end
    end

    always @(negedge sys_clk) begin
        logic [3:0] e;
        if (!rst) begin
            check({7'h00, fwd_valid}, {7'h00, cyc_seen});
            if (cyc_seen) begin
                e = exp_fwd.pop_front();
                check({7'h00, fwd_to_pci}, {7'h00, e[3]});
                check({7'h00, fwd_keep_isa}, {7'h00, !e[3]});
                check({5'h00, fwd_class}, {5'h00, e[2:0]});
            end
            if (rd_seen) check(reg_rdata, exp_rd.pop_front());
            else check(reg_rdata, 8'h00);
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Watchdog, about five times the sequence
    initial begin
        #500000;
        err_total++;
        finish_test();
    end

    initial begin
        {rst, ce, reg_wr, reg_rd, req, boot_rom_cs_enable} = 6'b110000;
        {reg_addr, reg_wdata, req_addr} = 40'h0;
        {ctl, rom, bot, top} = 32'h0100100F;
        {err_total, checks_done} = 0;
        lfsr = 24'h000028;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(fwd_dec_pkg::OFF_CONTROL, 8'h01);
        rd(fwd_dec_pkg::OFF_ROM_ENABLE, 8'h00);
        rd(fwd_dec_pkg::OFF_HOLE_BOTTOM, 8'h10);
        rd(fwd_dec_pkg::OFF_HOLE_TOP, 8'h0F);
        wr(8'h4C, 8'hFF);
        wr(fwd_dec_pkg::OFF_STATUS, 8'hFF);
        rd(8'h4C, 8'h00);
        rd(fwd_dec_pkg::OFF_STATUS, 8'h00);
        cyc(24'h100000, 1'b0);
        for (int c = 0; c < 32; c++) begin
            wr(fwd_dec_pkg::OFF_CONTROL, {lfsr[7:4], c[3:0]});
            for (int j = 0; j < 10; j++) cyc(low_tab[j], c[4]);
        end
        for (int i = 0; i < 12; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(fwd_dec_pkg::OFF_ROM_ENABLE, (i < 8) ? (8'h01 << i) : lfsr[7:0]);
            rd(fwd_dec_pkg::OFF_ROM_ENABLE, rom);
            for (int j = 0; j < 8; j++) cyc(24'h0C0000 | {7'h00, j[2:0], lfsr[13:0]}, 1'b0);
        end
        for (int k = 0; k < 200; k++) begin
            lfsr = lfsr_next(lfsr);
            wr(fwd_dec_pkg::OFF_CONTROL, lfsr[7:0]);
            wr(fwd_dec_pkg::OFF_ROM_ENABLE, lfsr[15:8]);
            wr(fwd_dec_pkg::OFF_HOLE_BOTTOM, 8'h10 + {1'b0, lfsr[22:16]});
            wr(fwd_dec_pkg::OFF_HOLE_TOP, bot + {2'b00, lfsr[13:8]} - 8'h04);
            rd(fwd_dec_pkg::OFF_HOLE_TOP, top);
            lfsr = lfsr_next(lfsr);
            case (lfsr[2:0])
                3'h0: a = {bot, 16'h0000};
                3'h1: a = {top, 16'hFFFF};
                3'h2: a = {bot - 8'h01, 16'hFFFF};
                3'h3: a = {top + 8'h01, 16'h0000};
                3'h4: a = {ctl[7:4], 20'hFFFFF};
                3'h5: a = {ctl[7:4] + 4'h1, 20'h00000};
                default: a = lfsr;
            endcase
            cyc(a, lfsr[23]);
            lfsr = lfsr_next(lfsr);
            cyc(lfsr, lfsr[23]);
            rd(fwd_dec_pkg::OFF_STATUS, {3'h0, last_exp[2:0], last_exp[3], top >= bot});
        end
        strobe(1'b0, 1'b0, 1'b0);
        strobe(1'b1, 1'b0, 1'b1);
        ce        <= 1'b0;
        reg_addr  <= fwd_dec_pkg::OFF_CONTROL;
        reg_wdata <= ~ctl;
        strobe(1'b0, 1'b0, 1'b0);
        ce <= 1'b1;
        rd(fwd_dec_pkg::OFF_CONTROL, ctl);
        strobe(1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge sys_clk);
        finish_test();
    end
endmodule : isa_to_pci_memory_forward_decoder_bench
